// File: logic/spsl_pkg.sv
// Package of constants and state type, plus the two-flop input synchroniser.
`timescale 1ns/1ps
`default_nettype none

package spsl_pkg;
  // Register indices on the plain register port.
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_DATA = 2'h1;
  localparam logic [1:0] ADDR_DIV = 2'h2;
  localparam logic [1:0] ADDR_STAT = 2'h3;
  // Control register field positions.
  localparam int CTRL_PE = 0;
  localparam int CTRL_ME = 1;
  localparam int CTRL_SM_LO = 2;
  localparam int CTRL_SM_HI = 3;
  localparam int CTRL_OVR = 4;
  localparam int CTRL_MODE_FAULT_FLAG = 5;
  localparam int CTRL_WCOL = 6;
  localparam int CTRL_DONE = 7;
  // Status register field positions.
  localparam int STAT_BUSY = 0;
  localparam int STAT_TXF = 1;
  localparam int STAT_SHF = 2;
  localparam int STAT_RXF = 3;
  // Select-mode encodings.
  localparam logic [1:0] SM_3WIRE = 2'h0;
  localparam logic [1:0] SM_4W_IN = 2'h1;
  // Reset values and the last bit index of a byte.
  localparam logic [1:0] SM_RESET = 2'h1;
  localparam logic [7:0] DIV_RESET = 8'h03;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Whole state of the port logic.
  typedef struct packed {
    logic pe;
    logic me;
    logic [1:0] smode;
    logic done_f;
    logic mode_fault_flag_f;
    logic wcol_f;
    logic ovr_f;
    logic [7:0] div;
    logic [7:0] txbuf;
    logic tx_full;
    logic [7:0] shreg;
    logic sh_full;
    logic [7:0] rxbuf;
    logic rx_full;
    logic busy;
    logic [7:0] hcnt;
    logic [2:0] bits;
    logic samp;
    logic sck;
    logic sck_p;
    logic sel_p;
    logic [7:0] rdata;
    logic mosi_out;
    logic mosi_oe;
    logic miso_out;
    logic miso_oe;
    logic sck_oe;
    logic sel_out;
    logic sel_oe;
    logic sel_routed;
  } spsl_state_t;
endpackage

// Two flip-flops per bit for inputs from outside the clock domain.
module spsl_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

`default_nettype wire

// File: logic/spsl_core.sv
// Serial port pin logic: master and slave engines, select-pin modes, registers.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1: Full-duplex, master or slave, 3/4 wire.
// RULE2: Master drives data-out line; slave listens.
// RULE3: Bytes shift most significant bit first.
// RULE4: Master data-out is shift register top.
// RULE5: Master samples return line; slave drives it.
// RULE6: Return line floats when disabled or unselected.
// RULE7: 3-wire slave always drives shift top.
// RULE8: Clock made only as master; slave follows.
// RULE9: Unselected 4-wire slave ignores serial clock.
// RULE10: Mode 00: 3-wire, slave always selected.
// RULE11: Mode 01: select input, low selects.
// RULE12: Mode 01 master: select fall disables master.
// RULE13: Mode 1x: select pin outputs low bit.
// RULE14: Software uses mode 1x only as master.
// RULE15: Select pin unrouted only in mode 00.
// RULE16: 3-wire slave must be bus's only slave.
// RULE17: Master data write loads shift, starts transfer.
// RULE18: Done flag set at end of byte.
// RULE19: Select fall clears enables, sets fault flag; the code does this only while mastering.
// RULE20: Select fall clears slave bit counter.
// RULE21: Select output changes only on software write.
module spsl_core (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic sel_in,
  output logic sel_out,
  output logic sel_oe,
  output logic sel_routed
);
  spsl_pkg::spsl_state_t st;
  spsl_pkg::spsl_state_t next_st;
  logic [3:0] pins_s;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic sel_s;
  logic sck_rise;
  logic sck_fall;
  logic sel_fall;
  logic slave_sel;
  logic master_on;
  logic slave_on;

  // Pin inputs pass two flip-flops before any logic sees them.
  spsl_sync #(.W(4)) u_sync (
    .clock(clock),
    .nrst(nrst),
    .d({sel_in, miso_in, mosi_in, sck_in}),
    .q(pins_s)
  );

  // A slave counts as selected always in mode 00, and on a low input in mode 01.
  function automatic logic sel_active(input logic [1:0] mode, input logic sel);
    return (mode == spsl_pkg::SM_3WIRE) | ((mode == spsl_pkg::SM_4W_IN) & ~sel);
  endfunction

  // Synchronised pins, their edges and the operating role.
  assign sck_s = pins_s[0];
  assign mosi_s = pins_s[1];
  assign miso_s = pins_s[2];
  assign sel_s = pins_s[3];
  assign sck_rise = sck_s & ~st.sck_p;
  assign sck_fall = ~sck_s & st.sck_p;
  assign sel_fall = ~sel_s & st.sel_p & (st.smode == spsl_pkg::SM_4W_IN);
  assign master_on = st.pe & st.me; // see RULE1
  assign slave_on = st.pe & ~st.me;
  // Mode 00 keeps a slave selected; mode 01 selects on a low input.
  assign slave_sel = sel_active(st.smode, sel_s); // see RULE10 see RULE11

  // Next-state logic: register access first, hardware events after so sets win.
  always_comb begin
    next_st = st;
    next_st.sck_p = sck_s;
    next_st.sel_p = sel_s;
    next_st.rdata = 8'h00;

    if (wr) begin
      case (addr)
        spsl_pkg::ADDR_CTRL: begin
          next_st.pe = wdata[spsl_pkg::CTRL_PE];
          next_st.me = wdata[spsl_pkg::CTRL_ME];
          next_st.smode = wdata[spsl_pkg::CTRL_SM_HI:spsl_pkg::CTRL_SM_LO];
          next_st.ovr_f = st.ovr_f & wdata[spsl_pkg::CTRL_OVR];
          next_st.mode_fault_flag_f = st.mode_fault_flag_f & wdata[spsl_pkg::CTRL_MODE_FAULT_FLAG];
          next_st.wcol_f = st.wcol_f & wdata[spsl_pkg::CTRL_WCOL];
          next_st.done_f = st.done_f & wdata[spsl_pkg::CTRL_DONE];
        end
        spsl_pkg::ADDR_DATA: begin
          if (st.tx_full) begin
            next_st.wcol_f = 1'b1;
          end else begin
            next_st.txbuf = wdata;
            next_st.tx_full = 1'b1;
          end
        end
        spsl_pkg::ADDR_DIV: begin
          next_st.div = wdata;
        end
        default: begin
        end
      endcase
    end

    if (rd) begin
      case (addr)
        spsl_pkg::ADDR_CTRL: begin
          next_st.rdata = {st.done_f, st.wcol_f, st.mode_fault_flag_f, st.ovr_f, st.smode, st.me, st.pe};
        end
        spsl_pkg::ADDR_DATA: begin
          next_st.rdata = st.rxbuf;
          next_st.rx_full = 1'b0;
        end
        spsl_pkg::ADDR_DIV: begin
          next_st.rdata = st.div;
        end
        spsl_pkg::ADDR_STAT: begin
          next_st.rdata = {4'h0, st.rx_full, st.sh_full, st.tx_full, st.busy};
        end
        default: begin
        end
      endcase
    end

    // An empty shift register takes the buffered byte; a master starts at once.
    if (st.tx_full && !st.sh_full && !st.busy) begin
      next_st.shreg = st.txbuf; // see RULE17
      next_st.sh_full = 1'b1;
      next_st.tx_full = 1'b0;
      if (master_on) begin
        next_st.busy = 1'b1;
        next_st.hcnt = 8'h00;
        next_st.bits = 3'h0;
        next_st.sck = 1'b0;
      end
    end

    // Master engine: the clock is generated here; sample on rise, shift on fall.
    if (st.busy) begin
      if (st.hcnt == st.div) begin
        next_st.hcnt = 8'h00;
        if (!st.sck) begin
          next_st.sck = 1'b1; // see RULE8
          next_st.samp = miso_s; // see RULE5
        end else begin
          next_st.sck = 1'b0;
          next_st.shreg = {st.shreg[6:0], st.samp}; // see RULE3
          next_st.bits = st.bits + 3'h1;
          if (st.bits == spsl_pkg::LAST_BIT) begin
            next_st.busy = 1'b0;
            next_st.sh_full = 1'b0;
            next_st.done_f = 1'b1; // see RULE18
            next_st.rxbuf = {st.shreg[6:0], st.samp};
            next_st.rx_full = 1'b1;
          end
        end
      end else begin
        next_st.hcnt = st.hcnt + 8'h01;
      end
    end

    // Slave engine: follows the outside clock only while selected.
    if (slave_on && slave_sel) begin // see RULE9
      if (sck_rise) begin
        next_st.samp = mosi_s; // see RULE2
      end else if (sck_fall) begin
        next_st.shreg = {st.shreg[6:0], st.samp}; // see RULE3
        next_st.bits = st.bits + 3'h1;
        if (st.bits == spsl_pkg::LAST_BIT) begin
          next_st.done_f = 1'b1; // see RULE18
          next_st.sh_full = 1'b0;
          if (st.rx_full && !(rd && addr == spsl_pkg::ADDR_DATA)) begin
            next_st.ovr_f = 1'b1;
          end else begin
            next_st.rxbuf = {st.shreg[6:0], st.samp};
            next_st.rx_full = 1'b1;
          end
        end
      end
    end

    // A falling select restarts the slave byte count.
    if (sel_fall && !st.me) begin
      next_st.bits = 3'h0; // see RULE20
    end

    // A falling select while mastering hands the bus to another master.
    if (sel_fall && master_on) begin
      next_st.me = 1'b0; // see RULE12 see RULE19
      next_st.pe = 1'b0;
      next_st.mode_fault_flag_f = 1'b1;
    end

    // A disabled port stops any transfer and clears the bit counter.
    if (!next_st.pe) begin
      next_st.busy = 1'b0;
      next_st.bits = 3'h0;
      next_st.sck = 1'b0;
    end

    // Pin drivers, taken from the next state so they are registered.
    next_st.mosi_out = next_st.shreg[7]; // see RULE4
    next_st.mosi_oe = next_st.pe & next_st.me; // see RULE2
    next_st.sck_oe = next_st.pe & next_st.me; // see RULE8
    next_st.miso_out = next_st.shreg[7]; // see RULE7
    next_st.miso_oe = next_st.pe & ~next_st.me &
                      sel_active(next_st.smode, sel_s); // see RULE5 see RULE6
    next_st.sel_oe = next_st.smode[1]; // see RULE13
    next_st.sel_out = next_st.smode[1] & next_st.smode[0]; // see RULE21
    next_st.sel_routed = (next_st.smode != spsl_pkg::SM_3WIRE); // see RULE15
  end

  // State register.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.smode <= spsl_pkg::SM_RESET;
      st.div <= spsl_pkg::DIV_RESET;
      st.sel_routed <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign rdata = st.rdata;
  assign sck_out = st.sck;
  assign sck_oe = st.sck_oe;
  assign mosi_out = st.mosi_out;
  assign mosi_oe = st.mosi_oe;
  assign miso_out = st.miso_out;
  assign miso_oe = st.miso_oe;
  assign sel_out = st.sel_out;
  assign sel_oe = st.sel_oe;
  assign sel_routed = st.sel_routed;

  // The data-out line follows the shift register top while mastering.
  chk_mosi_msb: assert property (@(posedge clock) disable iff (!nrst) // see RULE4
    mosi_oe |-> (mosi_out == st.shreg[7]))
    else $error("master data-out differs from shift register top");

  // A slave never drives the master-to-slave line or the clock.
  chk_slave_inputs: assert property (@(posedge clock) disable iff (!nrst) // see RULE2
    !st.me |-> (!mosi_oe && !sck_oe))
    else $error("slave drives data-out or clock");

  // A disabled port leaves the return line floating.
  chk_miso_hiz: assert property (@(posedge clock) disable iff (!nrst) // see RULE6
    !st.pe |-> !miso_oe)
    else $error("return line driven while disabled");

  // A 3-wire slave always drives its shift register top.
  chk_miso_3wire: assert property (@(posedge clock) disable iff (!nrst) // see RULE7
    (st.pe && !st.me && st.smode == spsl_pkg::SM_3WIRE) |->
      (miso_oe && miso_out == st.shreg[7]))
    else $error("3-wire slave not driving return line");

  // Select output mode drives the low mode bit.
  chk_sel_level: assert property (@(posedge clock) disable iff (!nrst) // see RULE13
    st.smode[1] |-> (sel_oe && sel_out == st.smode[0]))
    else $error("select output level wrong");

  // The select output never moves without a mode change.
  chk_sel_steady: assert property (@(posedge clock) disable iff (!nrst) // see RULE21
    $stable(st.smode) |-> $stable(sel_out))
    else $error("select output toggled by itself");

  // A select fall in multi-master mode disables the port and flags a fault.
  chk_mode_fault: assert property (@(posedge clock) disable iff (!nrst) // see RULE19
    (sel_fall && master_on) |=> (!st.me && !st.pe && st.mode_fault_flag_f && !st.busy))
    else $error("mode fault not taken");

  // A master transfer starts in the same cycle that an empty shift register is loaded.
  chk_master_start: assert property (@(posedge clock) disable iff (!nrst) // see RULE17
    (master_on && st.tx_full && !st.sh_full && !st.busy && !sel_fall && !wr) |=>
      (st.busy && st.sh_full && !st.tx_full))
    else $error("master transfer did not start");

  // Every finished master byte raises the done flag.
  chk_done_flag: assert property (@(posedge clock) disable iff (!nrst) // see RULE18
    ($fell(st.busy) && st.pe) |-> st.done_f)
    else $error("byte ended without done flag");

  // A select fall clears the slave byte count.
  chk_bits_clear: assert property (@(posedge clock) disable iff (!nrst) // see RULE20
    (sel_fall && !st.me) |=> (st.bits == 3'h0))
    else $error("slave bit counter not cleared");

  // Each master clock fall puts the next lower bit on the data-out line.
  chk_mosi_shift: assert property (@(posedge clock) disable iff (!nrst) // see RULE3
    ($fell(sck_out) && mosi_oe) |-> (mosi_out == $past(st.shreg[6])))
    else $error("master data-out not shifted in order");

  // An unselected slave neither counts bits nor finishes a byte.
  chk_unsel_idle: assert property (@(posedge clock) disable iff (!nrst) // see RULE9
    (slave_on && !slave_sel && !st.busy && !wr) |=> ($stable(st.bits) && !$rose(st.done_f)))
    else $error("unselected slave followed the serial clock");

  // A master never drives the return line.
  chk_master_miso: assert property (@(posedge clock) disable iff (!nrst) // see RULE5
    master_on |-> !miso_oe)
    else $error("master drives the return line");

  // Mode 01 keeps the select pin an input.
  chk_sel_input: assert property (@(posedge clock) disable iff (!nrst) // see RULE11
    (st.smode == spsl_pkg::SM_4W_IN) |-> !sel_oe)
    else $error("select pin driven in input mode");

  // Only mode 00 leaves the select signal off the pins.
  chk_sel_unrouted: assert property (@(posedge clock) disable iff (!nrst) // see RULE15
    sel_routed != (st.smode == spsl_pkg::SM_3WIRE))
    else $error("select routing does not match the mode");

  // The generated clock rests low whenever no master byte is running.
  chk_clock_idle: assert property (@(posedge clock) disable iff (!nrst) // see RULE8
    !st.busy |-> !sck_out)
    else $error("serial clock high outside a transfer");

  // A finished byte always leaves received data or an overrun behind it.
  chk_done_data: assert property (@(posedge clock) disable iff (!nrst) // see RULE18
    $rose(st.done_f) |-> (st.rx_full || st.ovr_f))
    else $error("done flag without received data");

  // A mode fault is only raised from mode 01.
  chk_fault_mode: assert property (@(posedge clock) disable iff (!nrst) // see RULE12
    $rose(st.mode_fault_flag_f) |-> ($past(st.smode) == spsl_pkg::SM_4W_IN))
    else $error("mode fault outside mode 01");
endmodule

`default_nettype wire

// File: bench/spsl_partner.sv
// Far-side serial device model: slave to a master port, or master clocking n bits.
`timescale 1ns/1ps
`default_nettype none

module spsl_partner (
  input wire logic sck_w,
  input wire logic mosi_w,
  input wire logic miso_w,
  output logic p_sck,
  output logic p_mosi,
  output logic p_miso
);
  logic pmaster;
  logic [7:0] tx;
  logic [7:0] rx;

  // Idle as a slave with the clock and data lines at rest.
  initial begin
    pmaster = 1'b0;
    tx = 8'h00;
    rx = 8'h00;
    p_sck = 1'b0;
    p_mosi = 1'b0;
  end

  // As the only slave, sample on the rising edge, most significant bit first.
  always @(posedge sck_w) begin
    if (!pmaster) begin
      rx <= {rx[6:0], mosi_w};
    end
  end

  // As slave, shift out on the falling edge; vacated bits take the inverse fill.
  always @(negedge sck_w) begin
    if (!pmaster) begin
      tx <= {tx[6:0], ~tx[0]};
    end
  end

  assign p_miso = tx[7];

  // As master, clock n bits of b at 64 ns per bit; the clock rests low between frames.
  task automatic xfer(input logic [7:0] b, input int n);
    pmaster = 1'b1;
    for (int i = 0; i < n; i++) begin
      p_mosi = b[7 - i];
      #32 p_sck = 1'b1;
      rx = {rx[6:0], miso_w};
      #32 p_sck = 1'b0;
    end
    p_mosi = ~p_mosi;
    pmaster = 1'b0;
  endtask
endmodule

`default_nettype wire

// File: bench/spsl_core_tb.sv
// Testbench for the serial port pin logic with a far-side device model.
`timescale 1ns/1ps
`default_nettype none

module spsl_core_tb;
  logic clock;
  logic nrst;
  logic [1:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic sel_out, sel_oe, sel_routed, sel_drv;
  logic sck_w, mosi_w, miso_w, sel_w, p_sck, p_mosi, p_miso;
  logic [7:0] v;
  int fail_count;
  int compares;

  // Each wire follows whichever side has its enable up.
  assign sck_w = sck_oe ? sck_out : p_sck;
  assign mosi_w = mosi_oe ? mosi_out : p_mosi;
  assign miso_w = miso_oe ? miso_out : p_miso;
  assign sel_w = sel_oe ? sel_out : sel_drv;

  // System clock of 4 ns period.
  always #2 clock = ~clock;

  spsl_core dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe), .mosi_in(mosi_w),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_out),
    .miso_oe(miso_oe), .sel_in(sel_w), .sel_out(sel_out), .sel_oe(sel_oe),
    .sel_routed(sel_routed));

  spsl_partner pm (.sck_w(sck_w), .mosi_w(mosi_w), .miso_w(miso_w), .p_sck(p_sck),
    .p_mosi(p_mosi), .p_miso(p_miso));

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Pin enables packed as sck, mosi, miso, select enable, select level, routed.
  task automatic pins(input logic [7:0] exp);
    chk("pins", {2'h0, sck_oe, mosi_oe, miso_oe, sel_oe, sel_out, sel_routed}, exp);
  endtask

  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [1:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // Poll the control register for the done flag under a bounded count.
  task automatic wait_done;
    int i;
    for (i = 0; i < 200; i++) begin
      rd_reg(spsl_pkg::ADDR_CTRL, v);
      if (v[spsl_pkg::CTRL_DONE] === 1'b1) break;
    end
    chk("done flag", {7'h00, v[spsl_pkg::CTRL_DONE]}, 8'h01);
    if (i == 200) test_done;
  endtask

  task automatic t_master3;
    wr_reg(spsl_pkg::ADDR_CTRL, 8'h03);
    settle;
    pins(8'h30);
    pm.tx = 8'h3C;
    wr_reg(spsl_pkg::ADDR_DATA, 8'hA5);
    wait_done;
    chk("mosi byte", pm.rx, 8'hA5);
    rd_reg(spsl_pkg::ADDR_DATA, v);
    chk("miso byte", v, 8'h3C);
    $display("test master 3-wire done");
  endtask

  task automatic t_master4;
    wr_reg(spsl_pkg::ADDR_CTRL, 8'h0B);
    settle;
    pins(8'h35);
    wr_reg(spsl_pkg::ADDR_CTRL, 8'h0F);
    settle;
    pins(8'h37);
    wr_reg(spsl_pkg::ADDR_DIV, 8'h02);
    rd_reg(spsl_pkg::ADDR_DIV, v);
    chk("div write", v, 8'h02);
    pm.tx = 8'hC3;
    wr_reg(spsl_pkg::ADDR_DATA, 8'h81);
    wait_done;
    pins(8'h37);
    chk("mosi byte", pm.rx, 8'h81);
    rd_reg(spsl_pkg::ADDR_DATA, v);
    chk("miso byte", v, 8'hC3);
    $display("test master 4-wire done");
  endtask

  task automatic t_fault;
    wr_reg(spsl_pkg::ADDR_CTRL, 8'h07);
    settle;
    pins(8'h31);
    @(posedge clock);
    sel_drv <= 1'b0;
    settle;
    rd_reg(spsl_pkg::ADDR_CTRL, v);
    chk("fault ctrl", v, 8'h24);
    pins(8'h01);
    @(posedge clock);
    sel_drv <= 1'b1;
    $display("test mode fault done");
  endtask

  task automatic t_slave3;
    wr_reg(spsl_pkg::ADDR_CTRL, 8'h01);
    wr_reg(spsl_pkg::ADDR_DATA, 8'h96);
    settle;
    pins(8'h08);
    wr_reg(spsl_pkg::ADDR_DATA, 8'h11);
    wr_reg(spsl_pkg::ADDR_DATA, 8'h22);
    rd_reg(spsl_pkg::ADDR_STAT, v);
    chk("slave stat", v, 8'h06);
    pm.xfer(8'h5A, 8);
    wait_done;
    chk("slave ctrl", v, 8'hC1);
    chk("slave miso", pm.rx, 8'h96);
    pm.xfer(8'h33, 8);
    settle;
    settle;
    chk("second miso", pm.rx, 8'h11);
    rd_reg(spsl_pkg::ADDR_DATA, v);
    chk("slave mosi", v, 8'h5A);
    rd_reg(spsl_pkg::ADDR_CTRL, v);
    chk("overrun ctrl", v, 8'hD1);
    $display("test slave 3-wire done");
  endtask

  task automatic t_slave4;
    wr_reg(spsl_pkg::ADDR_CTRL, 8'h05);
    settle;
    pins(8'h01);
    pm.xfer(8'hFF, 8);
    settle;
    rd_reg(spsl_pkg::ADDR_CTRL, v);
    chk("unselected", v, 8'h05);
    @(posedge clock);
    sel_drv <= 1'b0;
    settle;
    pins(8'h09);
    pm.xfer(8'h00, 3);
    @(posedge clock);
    sel_drv <= 1'b1;
    settle;
    @(posedge clock);
    sel_drv <= 1'b0;
    settle;
    pm.xfer(8'h5A, 8);
    wait_done;
    rd_reg(spsl_pkg::ADDR_DATA, v);
    chk("slave mosi", v, 8'h5A);
    $display("test slave 4-wire done");
  endtask

  task automatic t_off;
    wr_reg(spsl_pkg::ADDR_CTRL, 8'h00);
    settle;
    pins(8'h00);
    $display("test disabled done");
  endtask

  // Reset, then the scenarios in turn, then the verdict.
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    addr = 2'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    sel_drv = 1'b1;
    fail_count = 0;
    compares = 0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    #1;
    pins(8'h01);
    chk("rdata", rdata, 8'h00);
    rd_reg(spsl_pkg::ADDR_CTRL, v);
    chk("ctrl reset", v, 8'h04);
    rd_reg(spsl_pkg::ADDR_DIV, v);
    chk("div reset", v, spsl_pkg::DIV_RESET);
    rd_reg(spsl_pkg::ADDR_STAT, v);
    chk("stat reset", v, 8'h00);
    $display("test reset done");
    t_master3;
    t_master4;
    t_fault;
    t_slave3;
    t_slave4;
    t_off;
    test_done;
  end
endmodule

`default_nettype wire
